// >>> design/scbcfg_top.sv
/*
  smbus configuration slave of a four-pair clock buffer: bit-level smbus
  engine, eight-byte register bank, output gating and mode selection.
  assumes scl, sda and the strap/enable pins already synchronous to mclk,
  and that the reference clock arrives as a level sampled at mclk.
*/
`timescale 1ns/1ps
// Function
// RULE_01 - slave only, one seven-bit address
// RULE_02 - block write: offset, count, data, acked
// RULE_03 - block read after repeated start
// RULE_04 - offset byte picks first register
// RULE_05 - master never writes zero count
// RULE_06 - stop after any byte ends cleanly
// RULE_07 - silent unless reference clock runs
// RULE_08 - byte zero gate bits, reset enabled
// RULE_09 - cleared gate bit forces pair low
// RULE_10 - byte one top bits show strap
// RULE_11 - bit five picks soft mode source
// RULE_12 - soft mode bits inert unless selected
// RULE_13 - amplitude field, reset value two
// RULE_14 - per-pair edge rate, reset fast
// RULE_15 - reserved bits read fixed pattern
// RULE_16 - byte four reads all ones
// RULE_17 - byte five revision and maker codes
// RULE_18 - byte six type and part code
// RULE_19 - byte seven reads zero
// RULE_20 - active-low pin also gates pair
// RULE_21 - mode encoding low, bypass, high
// RULE_22 - gate change takes one to three clocks
// RULE_23 - straps caught on first power good
// RULE_24 - index advances, read-only writes ignored
// RULE_25 - read count spans offset to end
module scbcfg_top #(
  parameter logic [3:0] REVISION_CODE = 4'h3, // arbitrary value
  parameter logic [3:0] MAKER_CODE = 4'h5, // arbitrary value
  parameter logic [1:0] PART_TYPE = 2'h2, // arbitrary value
  parameter logic [5:0] PART_CODE = 6'h2a // arbitrary value
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // smbus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // reference clock level and power pins
  input wire logic ref_clk_level,
  input wire logic power_good_sleep_n,
  input wire logic [1:0] bandwidth_strap,
  // per-pair active-low enable pins
  input wire logic [3:0] pair_enable_pin_n,
  // output pair control
  output logic [3:0] pair_run,
  output logic [1:0] pll_mode,
  output logic [1:0] amplitude,
  output logic [3:0] edge_rate,
  output logic powered_down
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001, ST_RX = 7'b0000010, ST_RX_ACK = 7'b0000100,
    ST_TX = 7'b0001000, ST_TX_ACK = 7'b0010000, ST_TX_PREP = 7'b0100000,
    ST_WAIT = 7'b1000000
  } scbcfg_state_t;
  typedef enum logic [3:0] {
    PH_ADDR = 4'b0001, PH_OFS = 4'b0010, PH_CNT = 4'b0100,
    PH_DATA = 4'b1000
  } scbcfg_phase_t;

  scbcfg_state_t state; // bit engine state
  scbcfg_phase_t phase; // which byte of the write frame is next
  logic scl_q, sda_q; // previous pin samples for edge detection
  logic [2:0] bitcnt; // bit position within byte
  logic [7:0] shreg; // shift register
  logic [2:0] index; // current register index
  logic [7:0] remain; // data bytes left in write frame
  logic tx_count; // next transmitted byte is the count byte
  logic [7:0] gate_reg, pllamp_reg, edge_reg; // writable bytes
  logic [1:0] latched_mode; // strap value caught at first power good
  logic started; // first power-good assertion seen
  logic [6:0] ref_timer; // mclk cycles since last reference edge
  logic ref_q, ref_alive; // reference activity
  logic [1:0] gate_cnt [4]; // per-pair latency counters
  logic [3:0] gate_want; // combined enable per pair

  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start_cond = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_cond = scl_in & scl_q & ~sda_q & sda_in;
  wire [7:0] rx_byte = {shreg[6:0], sda_in};

  // read mux of the whole bank, reserved bits fixed
  function automatic logic [7:0] read_reg(input logic [2:0] ofs);
    case (ofs)
      scbcfg_pkg::OFS_OUTPUT_GATE: read_reg = gate_reg; // [RULE_08] [RULE_15]
      scbcfg_pkg::OFS_PLL_AMP: read_reg = {latched_mode,
        pllamp_reg[5:0]}; // [RULE_10] [RULE_15]
      scbcfg_pkg::OFS_EDGE_RATE: read_reg = edge_reg; // [RULE_14] [RULE_15]
      scbcfg_pkg::OFS_FREQ_RSVD: read_reg = scbcfg_pkg::FREQ_RSVD_VAL; // [RULE_15]
      scbcfg_pkg::OFS_RSVD_ONES: read_reg = scbcfg_pkg::RSVD_ONES_VAL; // [RULE_16]
      scbcfg_pkg::OFS_REV_VENDOR: read_reg = {REVISION_CODE,
        MAKER_CODE}; // [RULE_17]
      scbcfg_pkg::OFS_PART_TYPE: read_reg = {PART_TYPE, PART_CODE}; // [RULE_18]
      default: read_reg = scbcfg_pkg::XFER_LEN_VAL; // [RULE_19]
    endcase
  endfunction

  // pin history for edge and condition detection
  always_ff @(posedge mclk) begin
    if (srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      ref_q <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      ref_q <= ref_clk_level;
    end
  end

  // reference watchdog; a stopped clock silences the bus
  always_ff @(posedge mclk) begin
    if (srst) begin
      ref_timer <= '0;
      ref_alive <= 1'b0;
    end else if (ref_clk_level != ref_q) begin
      ref_timer <= '0;
      ref_alive <= 1'b1; // [RULE_07]
    end else if (ref_timer == 7'(scbcfg_pkg::REF_TIMEOUT - 1)) begin
      ref_alive <= 1'b0; // [RULE_07]
    end else begin
      ref_timer <= ref_timer + 7'h01;
    end
  end

  // strap capture on the first power-good high, sleep on later lows
  always_ff @(posedge mclk) begin
    if (srst) begin
      started <= 1'b0;
      latched_mode <= 2'h0;
      powered_down <= 1'b1;
    end else begin
      if (power_good_sleep_n && !started) begin
        started <= 1'b1;
        latched_mode <= bandwidth_strap; // [RULE_23]
      end
      powered_down <= ~power_good_sleep_n; // [RULE_23]
    end
  end

  // smbus bit engine; sda only ever pulled low
  always_ff @(posedge mclk) begin
    if (srst || !ref_alive) begin
      state <= ST_IDLE; // [RULE_07]
      phase <= PH_ADDR;
      bitcnt <= '0;
      shreg <= '0;
      index <= '0;
      remain <= '0;
      tx_count <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      gate_reg <= scbcfg_pkg::GATE_RESET;
      pllamp_reg <= scbcfg_pkg::PLL_AMP_RESET;
      edge_reg <= scbcfg_pkg::EDGE_RESET;
    end else if (stop_cond) begin
      state <= ST_IDLE; // completed bytes already stored [RULE_06]
      sda_oe <= 1'b0;
    end else if (start_cond) begin
      state <= ST_RX; // start or repeated start
      phase <= PH_ADDR;
      bitcnt <= '0;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: sda_oe <= 1'b0;
        ST_RX: if (scl_rise) begin
          shreg <= rx_byte;
          bitcnt <= bitcnt + 3'h1;
          if (bitcnt == 3'h7) begin
            state <= ST_WAIT;
            if (phase == PH_ADDR && rx_byte == scbcfg_pkg::ADDR_READ) begin
              tx_count <= 1'b1; // [RULE_03]
              state <= ST_RX_ACK;
            end else if (phase == PH_ADDR &&
                         rx_byte != scbcfg_pkg::ADDR_WRITE) begin
              state <= ST_IDLE; // not our address [RULE_01]
            end else begin
              state <= ST_RX_ACK; // [RULE_02]
              case (phase)
                PH_ADDR: phase <= PH_OFS;
                PH_OFS: begin
                  index <= rx_byte[2:0]; // [RULE_04]
                  phase <= PH_CNT;
                end
                PH_CNT: begin
                  remain <= rx_byte; // nonzero by master contract [RULE_05]
                  phase <= PH_DATA;
                end
                default: begin
                  if (remain != 8'h00) begin
                    case (index)
                      scbcfg_pkg::OFS_OUTPUT_GATE: gate_reg <=
                        (rx_byte & scbcfg_pkg::GATE_MASK) |
                        ~scbcfg_pkg::GATE_MASK; // [RULE_24]
                      scbcfg_pkg::OFS_PLL_AMP: pllamp_reg <=
                        (rx_byte & scbcfg_pkg::PLL_AMP_MASK) |
                        scbcfg_pkg::PLL_AMP_RSVD; // [RULE_24]
                      scbcfg_pkg::OFS_EDGE_RATE: edge_reg <=
                        (rx_byte & scbcfg_pkg::EDGE_MASK) |
                        ~scbcfg_pkg::EDGE_MASK; // [RULE_24]
                      default: ; // read-only bytes ignore writes [RULE_24]
                    endcase
                    remain <= remain - 8'h01;
                  end
                  index <= index + 3'h1; // [RULE_24]
                end
              endcase
            end
          end
        end
        ST_RX_ACK: if (scl_fall) begin
          sda_out <= 1'b0;
          sda_oe <= 1'b1; // ack every byte [RULE_02]
          state <= ST_WAIT;
        end
        ST_WAIT: if (scl_fall) begin
          sda_oe <= 1'b0;
          bitcnt <= '0;
          state <= tx_count ? ST_TX_PREP : ST_RX;
        end
        ST_TX_PREP: begin
          // count byte spans offset to end of bank [RULE_25]
          shreg <= tx_count ? 8'(scbcfg_pkg::LAST_OFFSET - {5'h00, index}
                                 + 8'h01) : read_reg(index);
          if (!tx_count) index <= index + 3'h1; // [RULE_24]
          tx_count <= 1'b0;
          state <= ST_TX;
          bitcnt <= '0;
        end
        ST_TX: begin
          sda_out <= 1'b0;
          sda_oe <= ~shreg[7]; // [RULE_03]
          if (scl_fall) begin
            shreg <= {shreg[6:0], 1'b0};
            bitcnt <= bitcnt + 3'h1;
            if (bitcnt == 3'h7) begin
              sda_oe <= 1'b0;
              state <= ST_TX_ACK;
            end
          end
        end
        ST_TX_ACK: if (scl_fall) begin
          // judge the ninth bit on the falling edge, from the sample
          // taken while scl was high; loading the next byte on the rise
          // would let this fall shift out its top bit unseen
          // master nack ends the read [RULE_03]
          state <= sda_q ? ST_IDLE : ST_TX_PREP;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // combine register bit and active-low pin per pair [RULE_09] [RULE_20]
  always_comb begin
    gate_want[0] = gate_reg[scbcfg_pkg::POS_PAIR0] & ~pair_enable_pin_n[0];
    gate_want[1] = gate_reg[scbcfg_pkg::POS_PAIR1] & ~pair_enable_pin_n[1];
    gate_want[2] = gate_reg[scbcfg_pkg::POS_PAIR2] & ~pair_enable_pin_n[2];
    gate_want[3] = gate_reg[scbcfg_pkg::POS_PAIR3] & ~pair_enable_pin_n[3];
  end

  // latency counters make the change clean after a fixed delay;
  // the enable pulse of the output clock is modelled as mclk here
  for (genvar p = 0; p < 4; p++) begin : g_pair
    always_ff @(posedge mclk) begin
      if (srst) begin
        gate_cnt[p] <= '0;
        pair_run[p] <= 1'b0;
      end else if (powered_down) begin
        gate_cnt[p] <= '0;
        pair_run[p] <= 1'b0;
      end else if (gate_want[p] == pair_run[p]) begin
        gate_cnt[p] <= '0;
      end else if (gate_cnt[p] == scbcfg_pkg::GATE_LAT_CNT - 2'h1) begin
        pair_run[p] <= gate_want[p]; // [RULE_22]
        gate_cnt[p] <= '0;
      end else begin
        gate_cnt[p] <= gate_cnt[p] + 2'h1;
      end
    end
  end

  // analog controls, mode source chosen by the soft select bit
  always_ff @(posedge mclk) begin
    if (srst) begin
      pll_mode <= 2'h0;
      amplitude <= 2'h2;
      edge_rate <= 4'hf;
    end else begin
      pll_mode <= pllamp_reg[scbcfg_pkg::POS_SOFT_SEL] ?
        pllamp_reg[scbcfg_pkg::POS_SOFT_MODE +: 2] :
        latched_mode; // [RULE_11] [RULE_12] [RULE_21]
      amplitude <= pllamp_reg[scbcfg_pkg::POS_AMP +: 2]; // [RULE_13]
      edge_rate <= {edge_reg[scbcfg_pkg::POS_PAIR3],
        edge_reg[scbcfg_pkg::POS_PAIR2], edge_reg[scbcfg_pkg::POS_PAIR1],
        edge_reg[scbcfg_pkg::POS_PAIR0]}; // [RULE_14]
    end
  end

  // assertions
  a_ref_silence: assert property (@(posedge mclk) disable iff (srst)
    !ref_alive |=> !sda_oe) else $error("sda driven without ref clock"); // [RULE_07]
  a_gate_forced: assert property (@(posedge mclk) disable iff (srst)
    !gate_reg[scbcfg_pkg::POS_PAIR0] [*4] |-> !pair_run[0])
    else $error("pair 0 runs with gate bit clear"); // [RULE_09]
  a_pin_forced: assert property (@(posedge mclk) disable iff (srst)
    pair_enable_pin_n[1] [*4] |-> !pair_run[1])
    else $error("pair 1 runs with pin high"); // [RULE_20]
  a_gate_latency: assert property (@(posedge mclk) disable iff (srst)
    (gate_want[2] && !powered_down) [*4] |-> pair_run[2])
    else $error("pair 2 late to start"); // [RULE_22]
  a_mode_soft: assert property (@(posedge mclk) disable iff (srst)
    $stable(pllamp_reg) && pllamp_reg[scbcfg_pkg::POS_SOFT_SEL] |=>
    pll_mode == $past(pllamp_reg[4:3]))
    else $error("soft mode not applied"); // [RULE_11]
  a_mode_strap: assert property (@(posedge mclk) disable iff (srst)
    !pllamp_reg[scbcfg_pkg::POS_SOFT_SEL] && $stable(latched_mode) |=>
    pll_mode == $past(latched_mode))
    else $error("strap mode not applied"); // [RULE_12]
  a_gate_rsvd: assert property (@(posedge mclk) disable iff (srst)
    (gate_reg | scbcfg_pkg::GATE_MASK) == 8'hff)
    else $error("gate reserved bits not ones"); // [RULE_15]
  a_amp_follow: assert property (@(posedge mclk) disable iff (srst)
    ##1 amplitude == $past(pllamp_reg[1:0]))
    else $error("amplitude not following"); // [RULE_13]
  a_stop_idle: assert property (@(posedge mclk) disable iff (srst)
    stop_cond && ref_alive |=> state == ST_IDLE && !sda_oe)
    else $error("stop not honoured"); // [RULE_06]
endmodule

// >>> inc/scbcfg_pkg.sv
/*
  constants for the clock buffer smbus configuration slave: register
  offsets, reset values, fixed read patterns, field positions, bus bytes.
  assumes nothing of its surroundings.
*/
package scbcfg_pkg;
  // bank geometry
  localparam int unsigned NUM_REGS = 8;
  localparam logic [7:0] LAST_OFFSET = 8'h07;
  // register offsets
  localparam logic [2:0] OFS_OUTPUT_GATE = 3'h0;
  localparam logic [2:0] OFS_PLL_AMP = 3'h1;
  localparam logic [2:0] OFS_EDGE_RATE = 3'h2;
  localparam logic [2:0] OFS_FREQ_RSVD = 3'h3;
  localparam logic [2:0] OFS_RSVD_ONES = 3'h4;
  localparam logic [2:0] OFS_REV_VENDOR = 3'h5;
  localparam logic [2:0] OFS_PART_TYPE = 3'h6;
  localparam logic [2:0] OFS_XFER_LEN = 3'h7;
  // writable masks and reset values
  localparam logic [7:0] GATE_MASK = 8'h6a;
  localparam logic [7:0] GATE_RESET = 8'hff;
  localparam logic [7:0] PLL_AMP_MASK = 8'h3b;
  localparam logic [7:0] PLL_AMP_RESET = 8'h06;
  localparam logic [7:0] PLL_AMP_RSVD = 8'h04;
  localparam logic [7:0] EDGE_MASK = 8'h6a;
  localparam logic [7:0] EDGE_RESET = 8'hff;
  localparam logic [7:0] FREQ_RSVD_VAL = 8'hc7;
  localparam logic [7:0] RSVD_ONES_VAL = 8'hff;
  localparam logic [7:0] XFER_LEN_VAL = 8'h00;
  // field positions
  localparam int unsigned POS_PAIR0 = 1;
  localparam int unsigned POS_PAIR1 = 3;
  localparam int unsigned POS_PAIR2 = 5;
  localparam int unsigned POS_PAIR3 = 6;
  localparam int unsigned POS_SOFT_SEL = 5;
  localparam int unsigned POS_SOFT_MODE = 3;
  localparam int unsigned POS_AMP = 0;
  // bus addresses with r/w bit, write and read
  localparam logic [7:0] ADDR_WRITE = 8'hd4;
  localparam logic [7:0] ADDR_READ = 8'hd5;
  // output latency in output clocks, 1 to 3
  localparam int unsigned GATE_LATENCY = 2;
  localparam logic [1:0] GATE_LAT_CNT = 2'(GATE_LATENCY);
  // reference clock watchdog: cycles of mclk with no ref edge
  localparam int unsigned REF_TIMEOUT = 64;
endpackage

// >>> verification/scbcfg_host.sv
/*
  behavioural smbus host master for the clock buffer config slave.
  assumes a pulled-up sda wire resolved by the bench from sda_low and
  the slave's enable; all bus timing is counted in mclk cycles.
*/
`timescale 1ns/1ps
module scbcfg_host (
  // clock
  input wire logic mclk,
  // bus wires
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // half a bus clock; eight mclk keeps well above the four-cycle minimum
  task automatic half();
    repeat (8) @(posedge mclk);
    #1;
  endtask

  // start, also a repeated start when entered with scl low
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask

  // stop after any whole byte ends the frame
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask

  // one bit: data set while scl low, sampled at the end of scl high
  task automatic xfer_bit(input logic b, output logic s);
    sda_low = !b;
    half();
    scl = 1'b1;
    half();
    s = sda;
    scl = 1'b0;
  endtask

  // eight bits msb first, then the ninth bit; tx of ff releases sda
  task automatic xfer_byte(input logic [7:0] tx, input logic ack_tx,
                           output logic [7:0] rx, output logic ack_rx);
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(tx[i], rx[i]);
    end
    xfer_bit(ack_tx, ack_rx);
  endtask
endmodule

// >>> verification/testbench.sv
/*
  self-checking bench for the clock buffer smbus configuration slave.
  assumes the slave takes synchronous levels on mclk and a host model
  that owns scl; the reference clock is a level toggled by the bench.
*/
`timescale 1ns/1ps
module testbench;
  localparam logic [3:0] REV = 4'h9; // arbitrary value
  localparam logic [3:0] MKR = 4'h6; // arbitrary value
  localparam logic [1:0] PTY = 2'h1; // arbitrary value
  localparam logic [5:0] PCD = 6'h11; // arbitrary value
  localparam logic [1:0] STRAP = 2'h1; // bypass strap at first power good
  logic mclk, srst, ref_lvl, ref_on, pg_n;
  logic [1:0] strap, pll_mode, amplitude;
  logic [3:0] pin_n, pair_run, edge_rate;
  logic scl, host_low, sda_oe, sda_out, powered_down;
  // pulled-up wire: low while either party pulls
  wire sda = !(host_low || (sda_oe && !sda_out));
  int n_mismatch = 0;
  int checks_done = 0;

  scbcfg_top #(.REVISION_CODE(REV), .MAKER_CODE(MKR), .PART_TYPE(PTY),
    .PART_CODE(PCD)) u_scbcfg_top (.mclk(mclk), .srst(srst),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .ref_clk_level(ref_lvl), .power_good_sleep_n(pg_n),
    .bandwidth_strap(strap), .pair_enable_pin_n(pin_n),
    .pair_run(pair_run), .pll_mode(pll_mode), .amplitude(amplitude),
    .edge_rate(edge_rate), .powered_down(powered_down));
  scbcfg_host u_scbcfg_host (.mclk(mclk), .scl(scl), .sda_low(host_low),
    .sda(sda));

  // 200 mhz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // reference clock runs while ref_on, stands still otherwise
  always @(posedge mclk) begin
    if (ref_on) begin
      ref_lvl <= ~ref_lvl;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // byte one as read: strap readback on top, bit two fixed high
  function automatic logic [7:0] b1(input logic [7:0] w);
    return {STRAP, (w[5:0] & 6'h3b) | 6'h04};
  endfunction

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // block write; fewer data than cnt ends the frame early by stop
  task automatic wr(input logic [7:0] ofs, input logic [7:0] cnt,
                    input logic [7:0] d[$]);
    logic [7:0] rx;
    logic a;
    d = {scbcfg_pkg::ADDR_WRITE, ofs, cnt, d};
    u_scbcfg_host.start();
    foreach (d[i]) begin
      u_scbcfg_host.xfer_byte(d[i], 1'b1, rx, a);
      check({7'h00, a}, 8'h00);
    end
    u_scbcfg_host.stop();
    wait_clk(4);
  endtask

  // block read of e.size() bytes from ofs, nack on the last
  task automatic rd(input logic [7:0] ofs, input logic [7:0] e[$]);
    logic [7:0] rx;
    logic a;
    u_scbcfg_host.start();
    u_scbcfg_host.xfer_byte(scbcfg_pkg::ADDR_WRITE, 1'b1, rx, a);
    u_scbcfg_host.xfer_byte(ofs, 1'b1, rx, a);
    u_scbcfg_host.start();
    u_scbcfg_host.xfer_byte(scbcfg_pkg::ADDR_READ, 1'b1, rx, a);
    check({7'h00, a}, 8'h00);
    u_scbcfg_host.xfer_byte(8'hff, 1'b0, rx, a);
    check(rx, 8'h08 - ofs);
    foreach (e[i]) begin
      u_scbcfg_host.xfer_byte(8'hff, i == e.size() - 1, rx, a);
      check(rx, e[i]);
    end
    u_scbcfg_host.stop();
    wait_clk(4);
  endtask

  // address only; returns the ninth bit seen on the wire
  task automatic probe(input logic [7:0] adr, output logic a);
    logic [7:0] rx;
    u_scbcfg_host.start();
    u_scbcfg_host.xfer_byte(adr, 1'b1, rx, a);
    u_scbcfg_host.stop();
  endtask

  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard, well above the whole sequence
  initial begin
    #500000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    logic a;
    srst = 1'b1;
    ref_on = 1'b1;
    ref_lvl = 1'b0;
    pg_n = 1'b0;
    strap = STRAP;
    pin_n = 4'h0;
    wait_clk(4);
    srst = 1'b0;
    pg_n = 1'b1;
    wait_clk(4);
    // strap moves after first power good; readback must not follow
    strap = 2'h3;
    wait_clk(4);
    check({4'h0, pair_run}, 8'h0f);
    check({6'h00, pll_mode}, 8'h01);
    check({6'h00, amplitude}, 8'h02);
    check({4'h0, edge_rate}, 8'h0f);
    rd(8'h00, '{8'hff, b1(8'h06), 8'hff, 8'hc7, 8'hff, {REV, MKR},
      {PTY, PCD}, 8'h00});
    wr(8'h00, 8'h03, '{8'h00, 8'h3f, 8'h00});
    rd(8'h00, '{8'h95, b1(8'h3f), 8'h95});
    check({4'h0, pair_run}, 8'h00);
    check({4'h0, edge_rate}, 8'h00);
    // every soft mode code and amplitude code
    for (int m = 0; m < 4; m++) begin
      wr(8'h01, 8'h01, '{8'h20 | 8'(m << 3) | 8'(m)});
      check({6'h00, pll_mode}, 8'(m));
      check({6'h00, amplitude}, 8'(m));
    end
    // soft mode bits inert while the source bit is clear
    wr(8'h01, 8'h01, '{8'h12});
    rd(8'h01, '{b1(8'h12)});
    check({6'h00, pll_mode}, 8'h01);
    // read-only bytes ignored, index wraps into byte zero
    wr(8'h06, 8'h03, '{8'h00, 8'hff, 8'h6a});
    rd(8'h05, '{{REV, MKR}, {PTY, PCD}, 8'h00});
    rd(8'h00, '{8'hff});
    wr(8'h03, 8'h02, '{8'h00, 8'h00});
    rd(8'h03, '{8'hc7, 8'hff});
    // write cut short by stop keeps the finished byte
    wr(8'h00, 8'h02, '{8'h40});
    check({4'h0, pair_run}, 8'h08);
    pin_n = 4'h8;
    wait_clk(4);
    check({4'h0, pair_run}, 8'h00);
    pin_n = 4'h0;
    // foreign address is not answered
    probe(8'ha0, a);
    check({7'h00, a}, 8'h01);
    // sleep forces pairs low
    pg_n = 1'b0;
    wait_clk(4);
    check({7'h00, powered_down}, 8'h01);
    check({4'h0, pair_run}, 8'h00);
    pg_n = 1'b1;
    // silent while the reference clock stands still
    ref_on = 1'b0;
    wait_clk(80);
    probe(scbcfg_pkg::ADDR_WRITE, a);
    check({7'h00, a}, 8'h01);
    ref_on = 1'b1;
    wait_clk(8);
    stop_test();
  end
endmodule
